// ### src/scan_ramp_generator.v
// scan ramp generator: APB registers, scan timer, ramp sequencer and interrupt
`timescale 1ns/1ps
`include "ramp_consts.vh"
module scan_ramp_generator #(
  parameter [15:0] SCAN_UNIT_CYCLES = `SCAN_UNIT_CYC
) (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // ramp results
  output reg [15:0] ramp_value_q,
  output reg [15:0] scan_count_q,
  // interrupt
  output wire irq
);

////////////////////////////////////////////////////////////////////////////////
// states

localparam [3:0] S_IDLE = 4'b0001;
localparam [3:0] S_RUN = 4'b0010;
localparam [3:0] S_CALC = 4'b0100;
localparam [3:0] S_HOLD = 4'b1000;

reg [3:0] state_q;
reg [2:0] ctrl_q;
reg [15:0] start_q;
reg [15:0] end_q;
reg [14:0] scans_q;
reg [15:0] period_q;
reg [1:0] status_q;
reg [1:0] mask_q;
reg [14:0] scans_run_q;
reg enable_prev_q;
reg [15:0] unit_cnt_q;
reg [15:0] period_cnt_q;
reg scan_tick_q;
reg div_go_q;
reg diff_neg_q;
reg [1:0] status_set;
reg [1:0] status_clr;
reg [14:0] scans_clamped;
reg [31:0] rd_mux;

wire wr_en;
wire rd_en;
wire enable;
wire end_mode;
wire fixed_scan;
wire enable_rise;
wire enable_fall;
wire [16:0] diff;
wire [16:0] diff_abs;
wire [31:0] product;
wire [31:0] quotient;
wire div_done;
wire [16:0] value_sum;
wire last_scan;

assign enable = ctrl_q[`CTRL_ENABLE];
assign end_mode = ctrl_q[`CTRL_END_MODE];
assign fixed_scan = ctrl_q[`CTRL_FIXED_SCAN];
assign enable_rise = enable & ~enable_prev_q;
assign enable_fall = ~enable & enable_prev_q;

////////////////////////////////////////////////////////////////////////////////
// apb access: zero wait states, error on unmapped offsets

// every access completes in its first access cycle
assign pready = 1'b1;
assign wr_en = psel & penable & pwrite;
assign rd_en = psel & penable & ~pwrite;

// pslverr stays a combinational answer; read data is picked in the setup cycle
always @*
begin
  pslverr = 1'b0;
  rd_mux = 32'h00000000;
  case (paddr)
    `OFS_CTRL: rd_mux = {29'h00000000, ctrl_q};
    `OFS_START: rd_mux = {16'h0000, start_q};
    `OFS_END: rd_mux = {16'h0000, end_q};
    `OFS_SCANS: rd_mux = {17'h00000, scans_q};
    `OFS_PERIOD: rd_mux = {16'h0000, period_q};
    `OFS_VALUE: rd_mux = {16'h0000, ramp_value_q};
    `OFS_COUNT: rd_mux = {16'h0000, scan_count_q};
    `OFS_STATUS: rd_mux = {30'h00000000, status_q};
    `OFS_MASK: rd_mux = {30'h00000000, mask_q};
    `OFS_STATE: rd_mux = {28'h0000000, state_q};
    default: pslverr = wr_en | rd_en;
  endcase
end

// latching in the setup cycle lets read data leave a flip-flop with no wait state
always @(posedge core_clk or negedge arst_n)
begin
  if (!arst_n)
    prdata <= 32'h00000000;
  else if (psel && !penable)
    prdata <= rd_mux;
end

// the scan total is clamped on entry so the divider never sees zero
always @*
begin
  scans_clamped = pwdata[14:0];
  if (pwdata[31:15] != 17'h00000)
    scans_clamped = `SCANS_MAX;
  else if (pwdata[14:0] == 15'h0000)
    scans_clamped = `SCANS_MIN;
end

always @(posedge core_clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    ctrl_q <= `RST_CTRL;
    start_q <= `RST_WORD;
    end_q <= `RST_WORD;
    scans_q <= `RST_SCANS;
    period_q <= `RST_WORD;
    mask_q <= `RST_STATUS;
  end
  else if (wr_en)
  begin
    case (paddr)
      `OFS_CTRL: ctrl_q <= pwdata[2:0];
      `OFS_START: start_q <= pwdata[15:0];
      `OFS_END: end_q <= pwdata[15:0];
      `OFS_SCANS: scans_q <= scans_clamped;
      `OFS_PERIOD: period_q <= pwdata[15:0];
      `OFS_MASK: mask_q <= pwdata[1:0];
      default: ;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// status: sticky, write one to clear, a new event wins over the clear

always @*
begin
  status_clr = 2'h0;
  if (wr_en && paddr == `OFS_STATUS)
    status_clr = pwdata[1:0];
end

localparam [1:0] STATUS_RST = `RST_STATUS;

// one sticky flip-flop per status bit
genvar gi;
generate
  for (gi = 0; gi < 2; gi = gi + 1)
  begin : g_status
    always @(posedge core_clk or negedge arst_n)
    begin
      if (!arst_n)
        status_q[gi] <= STATUS_RST[gi];
      else if (status_set[gi])
        status_q[gi] <= 1'b1;
      else if (status_clr[gi])
        status_q[gi] <= 1'b0;
    end
  end
endgenerate

assign irq = |(status_q & mask_q);

////////////////////////////////////////////////////////////////////////////////
// fixed scan timer: one tick per period_q milliseconds

// without the fixed scan enable or with a zero period the ramp simply stalls
always @(posedge core_clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    unit_cnt_q <= 16'h0000;
    period_cnt_q <= 16'h0000;
    scan_tick_q <= 1'b0;
  end
  else
  begin
    scan_tick_q <= 1'b0;
    if (!fixed_scan || period_q == 16'h0000 || enable_rise)
    begin
      unit_cnt_q <= 16'h0000;
      period_cnt_q <= 16'h0000;
    end
    else if (unit_cnt_q == SCAN_UNIT_CYCLES - 16'h0001)
    begin
      unit_cnt_q <= 16'h0000;
      if (period_cnt_q == period_q - 16'h0001)
      begin
        period_cnt_q <= 16'h0000;
        scan_tick_q <= 1'b1;
      end
      else
        period_cnt_q <= period_cnt_q + 16'h0001;
    end
    else
      unit_cnt_q <= unit_cnt_q + 16'h0001;
  end
end

////////////////////////////////////////////////////////////////////////////////
// ramp arithmetic: start + (end - start) * count / total

assign diff = {end_q[15], end_q} - {start_q[15], start_q};
assign diff_abs = diff[16] ? (17'h00000 - diff) : diff;
// |diff| < 2^17 and count < 2^15, so the product fits 32 bits
assign product = {15'h0000, diff_abs} * {17'h00000, scan_count_q[14:0]};

ramp_divider u_div (
  .core_clk(core_clk),
  .arst_n(arst_n),
  .go(div_go_q),
  .dividend(product),
  .divisor(scans_run_q),
  .quotient(quotient),
  .done(div_done)
);

// quotient never exceeds |diff| because count never exceeds total
assign value_sum = diff_neg_q ? ({start_q[15], start_q} - quotient[16:0])
                              : ({start_q[15], start_q} + quotient[16:0]);

// on the programmed scan end mode forces the end setting and the other mode the start setting, rather than trusting the divide
assign last_scan = (scan_count_q[14:0] == scans_run_q);

////////////////////////////////////////////////////////////////////////////////
// enable edge detector

// enable comes from a register on this clock, so it needs no synchroniser
always @(posedge core_clk or negedge arst_n)
begin
  if (!arst_n)
    enable_prev_q <= 1'b0;
  else
    enable_prev_q <= enable;
end

////////////////////////////////////////////////////////////////////////////////
// ramp sequencer

// enable edges win over every state, so a stop is never lost
always @(posedge core_clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    state_q <= S_IDLE;
    ramp_value_q <= `RST_WORD;
    scan_count_q <= `RST_WORD;
    scans_run_q <= `RST_SCANS;
    div_go_q <= 1'b0;
    diff_neg_q <= 1'b0;
    status_set <= 2'h0;
  end
  else
  begin
    div_go_q <= 1'b0;
    status_set <= 2'h0;
    if (enable_fall)
    begin
      state_q <= S_IDLE;
      status_set[`ST_STOPPED] <= 1'b1;
      if (!end_mode)
        ramp_value_q <= start_q;
    end
    else if (enable_rise)
    begin
      ramp_value_q <= 16'h0000;
      scan_count_q <= 16'h0000;
      scans_run_q <= scans_q;
      state_q <= S_RUN;
    end
    else
    begin
      case (state_q)
        S_IDLE: ;
        S_RUN:
        begin
          if (scan_tick_q)
          begin
            scan_count_q <= scan_count_q + 16'h0001;
            div_go_q <= 1'b1;
            diff_neg_q <= diff[16];
            state_q <= S_CALC;
          end
        end
        S_CALC:
        begin
          if (div_done)
          begin
            if (last_scan)
            begin
              status_set[`ST_COMPLETE] <= 1'b1;
              if (end_mode)
              begin
                ramp_value_q <= end_q;
                state_q <= S_HOLD;
              end
              else
              begin
                ramp_value_q <= start_q;
                scan_count_q <= 16'h0000;
                state_q <= S_RUN;
              end
            end
            else
            begin
              ramp_value_q <= value_sum[15:0];
              state_q <= S_RUN;
            end
          end
        end
        // a hold lasts until enable is cycled
        S_HOLD: ;
        default: state_q <= S_IDLE;
      endcase
    end
  end
end

endmodule // scan_ramp_generator

// ### src/ramp_consts.vh
// register map, field positions, reset values and timing constants of the scan ramp generator
`ifndef RAMP_CONSTS_VH
`define RAMP_CONSTS_VH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_START 8'h04
`define OFS_END 8'h08
`define OFS_SCANS 8'h0C
`define OFS_PERIOD 8'h10
`define OFS_VALUE 8'h14
`define OFS_COUNT 8'h18
`define OFS_STATUS 8'h1C
`define OFS_MASK 8'h20
`define OFS_STATE 8'h24

// control register bits
`define CTRL_ENABLE 0
`define CTRL_END_MODE 1
`define CTRL_FIXED_SCAN 2

// status and mask bits
`define ST_COMPLETE 0
`define ST_STOPPED 1

// reset values
`define RST_CTRL 3'h0
`define RST_WORD 16'h0000
`define RST_SCANS 15'h0001
`define RST_STATUS 2'h0

// scan count operand range
`define SCANS_MIN 15'h0001
`define SCANS_MAX 15'h7FFF

// timing: period word counts units of one millisecond
// clocks in one millisecond at the 25 ns core clock
`define SCAN_UNIT_CYC 16'h9C40
`define DIV_STEPS 6'h20

`endif

// ### src/ramp_divider.v
// serial restoring divider: 32-bit dividend over 15-bit divisor, one quotient bit per clock
`timescale 1ns/1ps
`include "ramp_consts.vh"
module ramp_divider (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // request
  input wire go,
  input wire [31:0] dividend,
  input wire [14:0] divisor,
  // answer
  output reg [31:0] quotient,
  output reg done
);

reg [15:0] rem_q;
reg [5:0] step_q;
reg busy_q;
reg [15:0] trial;

always @*
begin
  trial = {rem_q[14:0], quotient[31]};
end

// a go while busy is ignored; the caller only asks once per scan
always @(posedge core_clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    rem_q <= 16'h0000;
    step_q <= 6'h00;
    busy_q <= 1'b0;
    quotient <= 32'h00000000;
    done <= 1'b0;
  end
  else
  begin
    done <= 1'b0;
    if (!busy_q)
    begin
      if (go)
      begin
        quotient <= dividend;
        rem_q <= 16'h0000;
        step_q <= 6'h00;
        busy_q <= 1'b1;
      end
    end
    else
    begin
      if (trial >= {1'b0, divisor})
      begin
        rem_q <= trial - {1'b0, divisor};
        quotient <= {quotient[30:0], 1'b1};
      end
      else
      begin
        rem_q <= trial;
        quotient <= {quotient[30:0], 1'b0};
      end
      step_q <= step_q + 6'h01;
      if (step_q == `DIV_STEPS - 6'h01)
      begin
        busy_q <= 1'b0;
        done <= 1'b1;
      end
    end
  end
end

endmodule // ramp_divider

// ### verif/scan_ramp_generator_sva.sv
// bound assertions on the ports of the scan ramp generator
`timescale 1ns/1ps
`include "ramp_consts.vh"
module scan_ramp_generator_sva (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // results
  input wire [15:0] ramp_value_q,
  input wire [15:0] scan_count_q,
  input wire irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_rd(a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  // read data is latched in the setup cycle, one clock before the access edge
  property p_value_rd; s_rd(`OFS_VALUE) |-> prdata[15:0] == $past(ramp_value_q); endproperty
  a_value_rd: assert property (p_value_rd) else $error("value read differs from port");
  property p_count_rd; s_rd(`OFS_COUNT) |-> prdata[15:0] == $past(scan_count_q); endproperty
  a_count_rd: assert property (p_count_rd) else $error("count read differs from port");
  property p_count_step;
    $changed(scan_count_q) |-> scan_count_q == $past(scan_count_q) + 16'h0001 || scan_count_q == 16'h0000;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count moved by other than one");
  // a scan is far longer than eight clocks, so a double step shows here
  property p_count_gap; $changed(scan_count_q) && scan_count_q != 16'h0000 |=> $stable(scan_count_q) [*8]; endproperty
  a_count_gap: assert property (p_count_gap) else $error("count stepped twice in one scan");
  property p_count_max; scan_count_q <= 16'h7FFF; endproperty
  a_count_max: assert property (p_count_max) else $error("count above scan range");
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("access phase without ready");
  property p_err_map; psel && penable && paddr > `OFS_STATE |-> pslverr; endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped access not refused");
  property p_err_data; pslverr && !pwrite |-> prdata == 32'h0000_0000; endproperty
  a_err_data: assert property (p_err_data) else $error("refused read returns data");
  property p_irq_fall; $fell(irq) |-> $past(psel && penable && pwrite); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without a write");
endmodule // scan_ramp_generator_sva
bind scan_ramp_generator scan_ramp_generator_sva u_sva (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ramp_value_q(ramp_value_q), .scan_count_q(scan_count_q), .irq(irq));

// ### verif/prog_model.sv
// user program model: apb master that configures and starts ramps
`timescale 1ns/1ps
`include "ramp_consts.vh"
module prog_model (
  // clock
  input wire core_clk,
  // apb master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  int stalls;
  initial
  begin
    stalls = 0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    begin
      n = 0;
      r = 'x;
      e = 1'bx;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1 && n < 16)
      begin
        @(posedge core_clk);
        n++;
      end
      if (pready === 1'b1)
      begin
        r = prdata;
        e = pslverr;
      end
      else
        stalls++;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // stop first, so the scan total is only touched while no ramp runs
  task automatic start(input logic [15:0] s, input logic [15:0] t, input logic [14:0] n, input logic m);
    logic [31:0] r;
    logic x;
    begin
      xfer(1'b1, `OFS_CTRL, 32'h0000_0004, r, x);
      xfer(1'b1, `OFS_PERIOD, 32'h0000_0001, r, x);
      xfer(1'b1, `OFS_SCANS, {17'h00000, n}, r, x);
      xfer(1'b1, `OFS_START, {16'h0000, s}, r, x);
      xfer(1'b1, `OFS_END, {16'h0000, t}, r, x);
      xfer(1'b1, `OFS_CTRL, {29'h00000000, 1'b1, m, 1'b1}, r, x);
    end
  endtask
endmodule // prog_model

// ### verif/scan_ramp_generator_bench.sv
// self-checking bench of the scan ramp generator
`timescale 1ns/1ps
`include "ramp_consts.vh"
module scan_ramp_generator_bench;
  logic core_clk;
  logic arst_n;
  wire psel, penable, pwrite, pready, pslverr, irq;
  wire [7:0] paddr;
  wire [31:0] pwdata;
  wire [31:0] prdata;
  wire [15:0] ramp_value_q;
  wire [15:0] scan_count_q;
  int num_errors;
  int checks;
  logic [31:0] r;
  logic e;
  logic [15:0] s0;
  logic [15:0] t0;
  logic [31:0] sw[3];
  logic [31:0] se[3];
  prog_model u_prog_model (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // short scan unit keeps each scan at 50 clocks
  scan_ramp_generator #(.SCAN_UNIT_CYCLES(16'h0032)) u_scan_ramp_generator (.core_clk(core_clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ramp_value_q(ramp_value_q), .scan_count_q(scan_count_q), .irq(irq));
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    u_prog_model.xfer(1'b0, a, 32'h0000_0000, r, e);
    bus_guard();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_prog_model.xfer(1'b1, a, d, r, e);
    bus_guard();
    @(posedge core_clk);
  endtask
  // a bus wait that ran out of cycles ends the run as a mismatch
  task automatic bus_guard();
    if (u_prog_model.stalls != 0)
    begin
      num_errors++;
      wrap_up();
    end
  endtask
  function automatic logic [15:0] ramp_at(input logic [15:0] s, input logic [15:0] t, input int k, input int n);
    return 16'(int'($signed(s)) + (int'($signed(t)) - int'($signed(s))) * k / n);
  endfunction
  // the value settles well inside one 50-clock scan
  task automatic wait_count(input logic [15:0] c);
    int n;
    n = 0;
    while (scan_count_q !== c && n < 400)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n == 400)
    begin
      num_errors++;
      wrap_up();
    end
    repeat (45) @(posedge core_clk);
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    num_errors = 0;
    checks = 0;
    arst_n = 1'b0;
    s0 = 16'($urandom(32'h7FA1A243));
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(`OFS_STATE);
    chk(r, 32'h0000_0001);
    rd(8'h40);
    chk({r[31:1], e}, 32'h0000_0001);
    sw = '{32'h0000_0000, 32'h0001_0000, 32'($urandom_range(1, 32767))};
    se = '{32'h0000_0001, 32'h0000_7FFF, sw[2]};
    foreach (sw[i])
    begin
      wr(`OFS_SCANS, sw[i]);
      rd(`OFS_SCANS);
      chk(r, se[i]);
    end
    $display("registers done");
    wr(`OFS_MASK, 32'h0000_0001);
    t0 = 16'($urandom);
    u_prog_model.start(s0, t0, 15'h0003, 1'b0);
    bus_guard();
    for (int k = 1; k <= 2; k++)
    begin
      wait_count(16'(k));
      chk(ramp_value_q, ramp_at(s0, t0, k, 3));
    end
    wait_count(16'h0003);
    chk(ramp_value_q, s0);
    chk(scan_count_q, 16'h0000);
    chk(irq, 1'b1);
    wr(`OFS_STATUS, 32'h0000_0003);
    chk(irq, 1'b0);
    $display("mode clear done");
    s0 = 16'($urandom);
    t0 = 16'($urandom);
    u_prog_model.start(s0, t0, 15'h0002, 1'b1);
    bus_guard();
    repeat (3) @(posedge core_clk);
    chk(ramp_value_q, 16'h0000);
    wait_count(16'h0001);
    chk(ramp_value_q, ramp_at(s0, t0, 1, 2));
    wait_count(16'h0002);
    repeat (100) @(posedge core_clk);
    chk(ramp_value_q, t0);
    chk(scan_count_q, 16'h0002);
    rd(`OFS_VALUE);
    chk(r, {16'h0000, t0});
    rd(`OFS_COUNT);
    chk(r, 32'h0000_0002);
    wr(`OFS_CTRL, 32'h0000_0006);
    wr(`OFS_MASK, 32'h0000_0002);
    chk(ramp_value_q, t0);
    chk(irq, 1'b1);
    wr(`OFS_MASK, 32'h0000_0000);
    chk(irq, 1'b0);
    $display("mode set done");
    wrap_up();
  end
endmodule // scan_ramp_generator_bench
